// file: core/fer_params.svh
// Purpose: Offsets, field positions, reset values and counts of the fault event recorder.
// Assumes: Included by the recorder core only, after the package.
// Notes:   Register offsets are byte addresses within the slave's window.
`ifndef FER_PARAMS_SVH
`define FER_PARAMS_SVH

`define FER_ADDR_CTRL       8'h00
`define FER_ADDR_CMD        8'h04
`define FER_ADDR_NOMFREQ    8'h08
`define FER_ADDR_STATUS     8'h0c
`define FER_ADDR_SUM_TYPE   8'h10
`define FER_ADDR_SUM_IAB    8'h14
`define FER_ADDR_SUM_ICN    8'h18
`define FER_ADDR_SUM_IGVA   8'h1c
`define FER_ADDR_SUM_VBC    8'h20
`define FER_ADDR_SUM_START  8'h24

`define FER_CTRL_LONG_BIT   0
`define FER_CTRL_PRE_LSB    8
`define FER_CTRL_AUTO_LSB   16
`define FER_CTRL_LATCH_LSB  20
`define FER_CMD_TRIG_BIT    0
`define FER_CMD_CLEAR_BIT   1

`define FER_LEN_SHORT       7'h0f
`define FER_LEN_LONG        7'h40
`define FER_PRE_MIN         6'h01
`define FER_PRE_MAX_SHORT   6'h0a
`define FER_PRE_MAX_LONG    6'h3b
`define FER_PRE_RESET       6'h04
`define FER_SLOTS_SHORT     7'h4d
`define FER_SLOTS_LONG      7'h13
`define FER_TAIL_QCYC       9'h003
`define FER_NOMFREQ_RESET   16'h1770

`endif

// file: core/fer_pkg.sv
// Purpose: Types shared by the fault event recorder.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Event codes follow the classification priority, lowest code first.
package fer_pkg;

	typedef enum logic [0:0] {
		FER_ST_ARMED   = 1'b0,
		FER_ST_CAPTURE = 1'b1
	} fer_state_e;

	typedef enum logic [4:0] {
		FER_EV_ARC = 5'h00, FER_EV_FAULT = 5'h01,
		FER_EV_A50 = 5'h02, FER_EV_B50 = 5'h03, FER_EV_C50 = 5'h04, FER_EV_P50 = 5'h05,
		FER_EV_G50 = 5'h06, FER_EV_Q50 = 5'h07, FER_EV_A51 = 5'h08, FER_EV_B51 = 5'h09,
		FER_EV_C51 = 5'h0a, FER_EV_P51 = 5'h0b, FER_EV_G51 = 5'h0c, FER_EV_Q51 = 5'h0d,
		FER_EV_OV = 5'h0e, FER_EV_PF = 5'h0f, FER_EV_UF = 5'h10, FER_EV_OF = 5'h11,
		FER_EV_PWR = 5'h12, FER_EV_RTD = 5'h13, FER_EV_REM = 5'h14, FER_EV_UV = 5'h15,
		FER_EV_RTDF = 5'h16, FER_EV_BF = 5'h17, FER_EV_COMM = 5'h18,
		FER_EV_CMD = 5'h19, FER_EV_EQN = 5'h1a, FER_EV_TRIP = 5'h1b
	} fer_event_e;

endpackage : fer_pkg

// file: core/fer_recorder.sv
// Purpose: Fault event recorder: trigger, prefault ring, report commit, event typing, flags.
// Assumes: Sample strobe and protection inputs are synchronous to clk_sys_i.
// Notes:   Sample rows stream to an external nonvolatile store; summaries sit in registers.
`timescale 1ns/10ps
`include "fer_params.svh"

// Overview of operation
// (R1) Report length is 15 or 64 cycles.
// (R2) Prefault accepts 1-10 or 1-59 cycles.
// (R3) Prefault rows precede trigger, ring runs continuously.
// (R4) Prefault change leaves stored reports alone.
// (R5) Report length change erases all events.
// (R6) Store keeps newest 19 long or 77 short.
// (R7) Trip, equation or command starts a report.
// (R8) Equation triggers only on rising edge.
// (R9) Equation edge inside capture is ignored.
// (R10) Each event stores its summary record.
// (R11) Full store drops oldest report and summary.
// (R12) History clear erases reports and summaries; summary registers keep their values.
// (R13) Summary goes to auto-enabled ports.
// (R14) Type search by priority, arc-flash first.
// (R15) No match gives generic trip type.
// (R16) Fault labels get trip suffix on overcurrent.
// (R17) Frequency trip typed under or over nominal.
// (R18) Undervoltage type needs trip, no potential loss.
// (R19) Ground flag on residual pickup during event.
// (R20) Target latch only on trip inside window.
// (R21) Flags hold length minus prefault minus 0.75.
// (R22) Track maximum phase current row into summary.
// (R23) Commit only after post-trigger rows complete.
module fer_recorder #(
	parameter int SPC     = 16,
	parameter int N_PORTS = 4,
	parameter int DW      = 16,
	parameter int AW      = 15
) (
	input  wire logic               clk_sys_i,
	input  wire logic               reset_i,
	input  wire logic               hsel_i,
	input  wire logic [31:0]        haddr_i,
	input  wire logic [1:0]         htrans_i,
	input  wire logic               hwrite_i,
	input  wire logic [2:0]         hsize_i,
	input  wire logic [31:0]        hwdata_i,
	input  wire logic               hready_i,
	output logic                    hreadyout_o,
	output logic                    hresp_o,
	output logic [31:0]             hrdata_o,
	input  wire logic               sample_stb_i,
	input  wire logic [8*DW-1:0]    sample_row_i,
	input  wire logic               trip_i,
	input  wire logic               trigger_equation_i,
	input  wire logic               arc_flash_i,
	input  wire logic               fault_valid_i,
	input  wire logic [3:0]         fault_code_i,
	input  wire logic               oc_trip_i,
	input  wire logic [13:0]        cause_hi_i,
	input  wire logic [5:0]         freq_trip_i,
	input  wire logic [6*DW-1:0]    freq_pickup_i,
	input  wire logic [2:0]         cause_mid_i,
	input  wire logic               uv_trip_i,
	input  wire logic               potential_loss_flag_i,
	input  wire logic [2:0]         cause_lo_i,
	input  wire logic [2:0]         phase_inv_i,
	input  wire logic               resid_pickup_i,
	input  wire logic               target_reset_i,
	output logic                    store_wr_o,
	output logic [AW-1:0]           store_addr_o,
	output logic [8*DW-1:0]         store_wdata_o,
	output logic                    commit_o,
	output logic [6:0]              commit_slot_o,
	output logic                    erase_o,
	output logic [N_PORTS-1:0]      auto_msg_o,
	output logic [2:0]              phase_flag_o,
	output logic                    ground_fault_flag_o,
	output logic [3:0]              target_latch_o
);
	import fer_pkg::*;

	function automatic logic pre_ok(input logic lng, input logic [5:0] p);
		return (p >= `FER_PRE_MIN) && (p <= (lng ? `FER_PRE_MAX_LONG : `FER_PRE_MAX_SHORT));
	endfunction

	function automatic logic [10:0] cyc_to_rows(input logic [6:0] cyc);
		return 11'((32'(cyc) * SPC));
	endfunction

	fer_state_e          state_reg;
	logic                long_reg;
	logic [5:0]          pre_reg;
	logic [N_PORTS-1:0]  auto_en_reg;
	logic [3:0]          latch_cfg_reg;
	logic [15:0]         nomfreq_reg;
	logic                wr_pend_reg;
	logic [7:0]          wr_addr_reg;
	logic [31:0]         hrdata_reg;
	logic                trip_d_reg;
	logic                eqn_d_reg;
	logic [10:0]         wptr_reg;
	logic [10:0]         start_reg;
	logic [10:0]         post_left_reg;
	logic [6:0]          slot_reg;
	logic [6:0]          newest_reg;
	logic [6:0]          count_reg;
	fer_event_e          ev_type_reg;
	logic [3:0]          ev_code_reg;
	logic                ev_suffix_reg;
	logic [10:0]         max_row_reg;
	logic [8*DW-1:0]     max_vals_reg;
	logic [DW-1:0]       max_ph_reg;
	fer_event_e          sum_type_reg;
	logic [3:0]          sum_code_reg;
	logic                sum_suffix_reg;
	logic [10:0]         sum_row_reg;
	logic [10:0]         sum_start_reg;
	logic [8*DW-1:0]     sum_vals_reg;
	logic [13:0]         hold_reg;
	logic [2:0]          phase_flag_reg;
	logic                gflag_reg;
	logic [3:0]          target_reg;
	logic                store_wr_reg;
	logic [AW-1:0]       store_addr_reg;
	logic [8*DW-1:0]     store_wdata_reg;
	logic                commit_reg;
	logic                erase_reg;
	logic [N_PORTS-1:0]  auto_msg_reg;

	logic                addr_ok;
	logic                wr_now;
	logic                wr_ctrl;
	logic                cmd_trig;
	logic                erase_now;
	logic                trip_rise;
	logic                eqn_rise;
	logic                trig_now;
	logic                last_row;
	logic [10:0]         rep_rows;
	logic [10:0]         pre_rows;
	logic [6:0]          slots;
	logic [DW-1:0]       ph_max;
	fer_event_e          cls_type;
	logic [13:0]         hold_next;

	assign addr_ok   = hsel_i && htrans_i[1] && hready_i;
	assign wr_now    = wr_pend_reg;
	assign wr_ctrl   = wr_now && (wr_addr_reg == `FER_ADDR_CTRL);
	assign cmd_trig  = wr_now && (wr_addr_reg == `FER_ADDR_CMD) && hwdata_i[`FER_CMD_TRIG_BIT];
	// A length change moves slot boundaries, so old reports can no longer be found.
	assign erase_now = (wr_now && (wr_addr_reg == `FER_ADDR_CMD) && hwdata_i[`FER_CMD_CLEAR_BIT])
		|| (wr_ctrl && (hwdata_i[`FER_CTRL_LONG_BIT] != long_reg)); // see (R5) (R12)
	assign trip_rise = trip_i && !trip_d_reg;
	assign eqn_rise  = trigger_equation_i && !eqn_d_reg; // see (R8)
	assign trig_now  = (state_reg == FER_ST_ARMED) && !erase_now
		&& (trip_rise || eqn_rise || cmd_trig); // see (R7) (R9)
	assign rep_rows  = cyc_to_rows(long_reg ? `FER_LEN_LONG : `FER_LEN_SHORT); // see (R1)
	assign pre_rows  = cyc_to_rows({1'b0, pre_reg});
	assign slots     = long_reg ? `FER_SLOTS_LONG : `FER_SLOTS_SHORT; // see (R6)
	assign last_row  = (state_reg == FER_ST_CAPTURE) && sample_stb_i && (post_left_reg == 11'h001);
	assign ph_max    = (sample_row_i[DW-1:0] > sample_row_i[2*DW-1:DW])
		? ((sample_row_i[DW-1:0] > sample_row_i[3*DW-1:2*DW])
			? sample_row_i[DW-1:0] : sample_row_i[3*DW-1:2*DW])
		: ((sample_row_i[2*DW-1:DW] > sample_row_i[3*DW-1:2*DW])
			? sample_row_i[2*DW-1:DW] : sample_row_i[3*DW-1:2*DW]);
	// Flag time in quarter cycles, then rows: (length - prefault) * 4 - 3 quarters.
	assign hold_next = 14'((32'(((long_reg ? `FER_LEN_LONG : `FER_LEN_SHORT) - 7'(pre_reg)) * 4
		- `FER_TAIL_QCYC) * SPC) / 4); // see (R21)

	always_comb
	begin
		cls_type = FER_EV_TRIP; // see (R15)
		if (!trip_i)
			cls_type = cmd_trig ? FER_EV_CMD : (eqn_rise ? FER_EV_EQN : FER_EV_TRIP);
		else if (cause_lo_i[0])
			cls_type = FER_EV_RTDF; // see (R14)
		else if (cause_lo_i[1])
			cls_type = FER_EV_BF;
		else if (cause_lo_i[2])
			cls_type = FER_EV_COMM;
		if (uv_trip_i && !potential_loss_flag_i && trip_i)
			cls_type = FER_EV_UV; // see (R18)
		for (int i = 2; i >= 0; i--)
			if (cause_mid_i[i] && trip_i)
				cls_type = fer_event_e'(5'(32'(FER_EV_PWR) + i));
		// Any underfrequency element outranks every overfrequency one.
		for (int i = 0; i < 6; i++)
			if (freq_trip_i[i] && trip_i && (freq_pickup_i[i*DW +: DW] > nomfreq_reg))
				cls_type = FER_EV_OF; // see (R17)
		for (int i = 0; i < 6; i++)
			if (freq_trip_i[i] && trip_i && (freq_pickup_i[i*DW +: DW] < nomfreq_reg))
				cls_type = FER_EV_UF; // see (R17)
		for (int i = 13; i >= 0; i--)
			if (cause_hi_i[i] && trip_i)
				cls_type = fer_event_e'(5'(32'(FER_EV_A50) + i));
		if (fault_valid_i)
			cls_type = FER_EV_FAULT;
		if (arc_flash_i && trip_i)
			cls_type = FER_EV_ARC; // see (R14)
	end

	// Bus slave: zero wait states, read data registered at the address phase.
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata_reg  <= 32'h00000000;
		end
		else
		begin
			wr_pend_reg <= addr_ok && hwrite_i && (haddr_i[31:8] == 24'h000000);
			wr_addr_reg <= haddr_i[7:0];
			hrdata_reg  <= 32'h00000000;
			if (addr_ok && !hwrite_i && (haddr_i[31:8] == 24'h000000))
			begin
				case (haddr_i[7:0])
					`FER_ADDR_CTRL:      hrdata_reg <= {8'h00, latch_cfg_reg, 4'(auto_en_reg),
						2'b00, pre_reg, 7'h00, long_reg};
					`FER_ADDR_NOMFREQ:   hrdata_reg <= {16'h0000, nomfreq_reg};
					`FER_ADDR_STATUS:    hrdata_reg <= {7'h00, state_reg, 1'b0, newest_reg,
						9'h000, count_reg};
					`FER_ADDR_SUM_TYPE:  hrdata_reg <= {5'h00, sum_row_reg, 6'h00, sum_suffix_reg,
						sum_code_reg, sum_type_reg};
					`FER_ADDR_SUM_IAB:   hrdata_reg <= 32'(sum_vals_reg[2*DW-1:0]);
					`FER_ADDR_SUM_ICN:   hrdata_reg <= 32'(sum_vals_reg[4*DW-1:2*DW]);
					`FER_ADDR_SUM_IGVA:  hrdata_reg <= 32'(sum_vals_reg[6*DW-1:4*DW]);
					`FER_ADDR_SUM_VBC:   hrdata_reg <= 32'(sum_vals_reg[8*DW-1:6*DW]);
					`FER_ADDR_SUM_START: hrdata_reg <= {21'h000000, sum_start_reg};
					default:             hrdata_reg <= 32'h00000000;
				endcase
			end
		end
	end

	// Settings. An out-of-range prefault write is refused; the old value is kept, or set to 10 if it is out of range for the new length.
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			long_reg      <= 1'b0;
			pre_reg       <= `FER_PRE_RESET;
			auto_en_reg   <= '0;
			latch_cfg_reg <= 4'h0;
			nomfreq_reg   <= `FER_NOMFREQ_RESET;
		end
		else if (wr_ctrl)
		begin
			long_reg      <= hwdata_i[`FER_CTRL_LONG_BIT];
			auto_en_reg   <= hwdata_i[`FER_CTRL_AUTO_LSB +: N_PORTS];
			latch_cfg_reg <= hwdata_i[`FER_CTRL_LATCH_LSB +: 4];
			if (pre_ok(hwdata_i[`FER_CTRL_LONG_BIT], hwdata_i[`FER_CTRL_PRE_LSB +: 6]))
				pre_reg <= hwdata_i[`FER_CTRL_PRE_LSB +: 6]; // see (R2)
			else if (!pre_ok(hwdata_i[`FER_CTRL_LONG_BIT], pre_reg))
				pre_reg <= `FER_PRE_MAX_SHORT;
		end
		else if (wr_now && (wr_addr_reg == `FER_ADDR_NOMFREQ))
			nomfreq_reg <= hwdata_i[15:0];
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			trip_d_reg <= 1'b0;
			eqn_d_reg  <= 1'b0;
		end
		else
		begin
			trip_d_reg <= trip_i;
			eqn_d_reg  <= trigger_equation_i;
		end
	end

	// Rows stream into the filling slot as a ring, so prefault history is there once pre_rows rows have gone in after reset, erase or commit.
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			wptr_reg        <= 11'h000;
			store_wr_reg    <= 1'b0;
			store_addr_reg  <= '0;
			store_wdata_reg <= '0;
		end
		else
		begin
			store_wr_reg <= sample_stb_i && !erase_now;
			if (erase_now)
				wptr_reg <= 11'h000;
			else if (sample_stb_i)
			begin
				store_addr_reg  <= AW'(32'(slot_reg) * 32'(rep_rows) + 32'(wptr_reg));
				store_wdata_reg <= sample_row_i;
				wptr_reg        <= (wptr_reg + 11'h001 >= rep_rows) ? 11'h000
					: wptr_reg + 11'h001; // see (R3)
			end
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			state_reg     <= FER_ST_ARMED;
			start_reg     <= 11'h000;
			post_left_reg <= 11'h000;
			ev_type_reg   <= FER_EV_TRIP;
			ev_code_reg   <= 4'h0;
			ev_suffix_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				FER_ST_ARMED:
				begin
					if (trig_now)
					begin
						state_reg     <= FER_ST_CAPTURE;
						// Prefault is taken now; later prefault changes touch no report.
						start_reg     <= (wptr_reg >= pre_rows) ? wptr_reg - pre_rows
							: wptr_reg + rep_rows - pre_rows; // see (R4)
						post_left_reg <= rep_rows - pre_rows;
						ev_type_reg   <= cls_type;
						ev_code_reg   <= fault_code_i;
						ev_suffix_reg <= (cls_type == FER_EV_FAULT) && oc_trip_i; // see (R16)
					end
				end
				FER_ST_CAPTURE:
				begin
					if (erase_now || last_row)
						state_reg <= FER_ST_ARMED; // see (R23)
					if (sample_stb_i)
						post_left_reg <= post_left_reg - 11'h001;
					// A trip after a command or equation start gives the event its cause.
					if (trip_i && ((ev_type_reg == FER_EV_CMD) || (ev_type_reg == FER_EV_EQN)))
					begin
						ev_type_reg   <= cls_type; // see (R14)
						ev_code_reg   <= fault_code_i;
						ev_suffix_reg <= (cls_type == FER_EV_FAULT) && oc_trip_i; // see (R16)
					end
					else if (ev_type_reg == FER_EV_FAULT && oc_trip_i)
						ev_suffix_reg <= 1'b1; // see (R16)
				end
				default: state_reg <= FER_ST_ARMED;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i || trig_now)
		begin
			max_ph_reg   <= '0;
			max_row_reg  <= 11'h000;
			max_vals_reg <= '0;
		end
		else if ((state_reg == FER_ST_CAPTURE) && sample_stb_i && (ph_max >= max_ph_reg))
		begin
			max_ph_reg   <= ph_max;
			max_row_reg  <= rep_rows - post_left_reg; // see (R22)
			max_vals_reg <= sample_row_i;
		end
	end

	// Commit: report and summary become visible together, oldest slot reused first.
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			slot_reg       <= 7'h00;
			newest_reg     <= 7'h00;
			count_reg      <= 7'h00;
			commit_reg     <= 1'b0;
			erase_reg      <= 1'b0;
			auto_msg_reg   <= '0;
			sum_type_reg   <= FER_EV_TRIP;
			sum_code_reg   <= 4'h0;
			sum_suffix_reg <= 1'b0;
			sum_row_reg    <= 11'h000;
			sum_start_reg  <= 11'h000;
			sum_vals_reg   <= '0;
		end
		else
		begin
			commit_reg   <= 1'b0;
			erase_reg    <= erase_now;
			auto_msg_reg <= '0;
			if (erase_now)
			begin
				slot_reg  <= 7'h00; // see (R5) (R12)
				count_reg <= 7'h00;
			end
			else if (last_row)
			begin
				commit_reg     <= 1'b1; // see (R10) (R23)
				auto_msg_reg   <= auto_en_reg; // see (R13)
				newest_reg     <= slot_reg;
				slot_reg       <= (slot_reg + 7'h01 >= slots) ? 7'h00 : slot_reg + 7'h01; // see (R11)
				count_reg      <= (count_reg >= slots) ? slots : count_reg + 7'h01; // see (R6)
				sum_type_reg   <= ev_type_reg;
				sum_code_reg   <= ev_code_reg;
				sum_suffix_reg <= ev_suffix_reg;
				sum_row_reg    <= max_row_reg;
				sum_start_reg  <= start_reg;
				sum_vals_reg   <= max_vals_reg; // see (R22)
			end
		end
	end

	// Flags hold a fixed row count from the trigger; latches wait for a trip inside it.
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i || erase_now)
		begin
			hold_reg       <= 14'h0000;
			phase_flag_reg <= 3'h0;
			gflag_reg      <= 1'b0;
		end
		else if (trig_now)
		begin
			hold_reg       <= hold_next; // see (R21)
			phase_flag_reg <= phase_inv_i;
			gflag_reg      <= resid_pickup_i; // see (R19)
		end
		else if (hold_reg != 14'h0000)
		begin
			if (sample_stb_i)
				hold_reg <= hold_reg - 14'h0001;
			if (sample_stb_i && (hold_reg == 14'h0001))
			begin
				phase_flag_reg <= 3'h0;
				gflag_reg      <= 1'b0;
			end
			else
			begin
				phase_flag_reg <= phase_flag_reg | phase_inv_i;
				gflag_reg      <= gflag_reg | resid_pickup_i; // see (R19)
			end
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			target_reg <= 4'h0;
		else if (trip_rise && (state_reg == FER_ST_CAPTURE))
			target_reg <= target_reg | (latch_cfg_reg & {gflag_reg, phase_flag_reg}); // see (R20)
		else if (target_reset_i)
			target_reg <= 4'h0;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			hreadyout_o <= 1'b0;
		else
			hreadyout_o <= 1'b1;
	end

	assign hresp_o             = 1'b0;
	assign hrdata_o            = hrdata_reg;
	assign store_wr_o          = store_wr_reg;
	assign store_addr_o        = store_addr_reg;
	assign store_wdata_o       = store_wdata_reg;
	assign commit_o            = commit_reg;
	assign commit_slot_o       = newest_reg;
	assign erase_o             = erase_reg;
	assign auto_msg_o          = auto_msg_reg;
	assign phase_flag_o        = phase_flag_reg;
	assign ground_fault_flag_o = gflag_reg;
	assign target_latch_o      = target_reg;

	chk_pre_range: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R2)
		pre_ok(long_reg, pre_reg)) else $error("prefault setting out of range");
	chk_len_erase: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R5)
		(wr_ctrl && (hwdata_i[0] != long_reg)) |=> (count_reg == 7'h00) && erase_o)
		else $error("length change did not erase events");
	chk_clear_all: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R12)
		(wr_now && (wr_addr_reg == 8'h04) && hwdata_i[1]) |=> (count_reg == 7'h00) && !commit_o)
		else $error("history clear left events");
	chk_eqn_level: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R8)
		((state_reg == FER_ST_ARMED) && trigger_equation_i && $past(trigger_equation_i)
		&& !trip_rise && !cmd_trig) |=> (state_reg == FER_ST_ARMED))
		else $error("held equation level started a report");
	chk_eqn_window: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R9)
		((state_reg == FER_ST_CAPTURE) && eqn_rise && !last_row && !erase_now)
		|=> (state_reg == FER_ST_CAPTURE) && $stable(start_reg))
		else $error("equation edge restarted a running capture");
	chk_count_cap: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R6)
		commit_o |-> (count_reg <= slots) && (count_reg != 7'h00))
		else $error("event count beyond store capacity");
	chk_auto_msg: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R13)
		commit_o |-> (auto_msg_o == $past(auto_en_reg)) ##1 (auto_msg_o == '0))
		else $error("summary not sent to enabled ports");
	chk_commit_post: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R23)
		commit_o |-> ($past(post_left_reg) == 11'h001) && $past(sample_stb_i)
		&& (state_reg == FER_ST_ARMED))
		else $error("report committed before post rows done");
	chk_hold_time: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R21)
		trig_now |=> (hold_reg == $past(hold_next)))
		else $error("flag hold time wrong");
	chk_arc_first: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (R14)
		(trig_now && arc_flash_i && trip_i) |=> (ev_type_reg == FER_EV_ARC))
		else $error("arc-flash trip not typed first");

endmodule // fer_recorder

// file: verif/fault_event_recorder_test.sv
// Purpose: Self-checking bench of the fault event recorder.
// Assumes: Four rows per cycle (SPC 4), so a short report has 56 post rows at prefault 1.
// Notes:   Register access is by single AHB-Lite word transfers.
`timescale 1ns/10ps
module fault_event_recorder_test;
	import fer_pkg::*;
	typedef struct packed {
		logic arc; logic fv; logic oc; logic [13:0] hi; logic [5:0] fq;
		logic uv; logic potential_loss_flag; logic [2:0] mid; logic [2:0] lo; fer_event_e ev;
	} fer_row_s;
	logic        clk_sys_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        hsel = 1'b0, hwrite = 1'b0, hro, hresp, stb, wr, cmt, ers, gnd;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	logic [127:0] row, wdata;
	logic        trip = 1'b0, eqn = 1'b0, arc = 1'b0, fv = 1'b0, oc = 1'b0;
	logic        uv = 1'b0, potential_loss_flag = 1'b0, trst = 1'b0;
	logic [2:0]  mid = 3'h0, lo = 3'h0;
	logic [13:0] hi = 14'h0;
	logic [5:0]  fq = 6'h0;
	logic [3:0]  amsg, tl;
	logic [2:0]  pf;
	logic [14:0] sa;
	logic [6:0]  cs;
	int          n_mismatch = 0, n_tests = 0, n_erase = 0, i;
	fer_row_s    tbl [11] = '{
		'{1'b1,1'b0,1'b0,14'h0000,6'h00,1'b0,1'b0,3'h0,3'h0,FER_EV_ARC},
		'{1'b0,1'b1,1'b1,14'h0001,6'h00,1'b0,1'b0,3'h0,3'h0,FER_EV_FAULT},
		'{1'b0,1'b1,1'b0,14'h0000,6'h00,1'b0,1'b0,3'h0,3'h0,FER_EV_FAULT},
		'{1'b0,1'b0,1'b0,14'h2001,6'h00,1'b0,1'b0,3'h0,3'h0,FER_EV_A50},
		'{1'b0,1'b0,1'b0,14'h2000,6'h00,1'b0,1'b0,3'h0,3'h0,FER_EV_PF},
		'{1'b0,1'b0,1'b0,14'h0000,6'h04,1'b0,1'b0,3'h0,3'h0,FER_EV_UF},
		'{1'b0,1'b0,1'b0,14'h0000,6'h00,1'b1,1'b0,3'h0,3'h0,FER_EV_UV},
		'{1'b0,1'b0,1'b0,14'h0000,6'h00,1'b1,1'b1,3'h0,3'h0,FER_EV_TRIP},
		'{1'b0,1'b0,1'b0,14'h0000,6'h00,1'b0,1'b0,3'h2,3'h4,FER_EV_RTD},
		'{1'b0,1'b0,1'b0,14'h0000,6'h00,1'b0,1'b0,3'h0,3'h6,FER_EV_BF},
		'{1'b0,1'b0,1'b0,14'h0000,6'h00,1'b0,1'b0,3'h0,3'h0,FER_EV_TRIP}};
	always #4 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) if (ers === 1'b1) n_erase++;
	fer_feed feed_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .sample_stb_o(stb),
		.sample_row_o(row));
	fer_recorder #(.SPC(4)) dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
		.hwdata_i(hwdata), .hready_i(hro), .hreadyout_o(hro), .hresp_o(hresp),
		.hrdata_o(hrdata), .sample_stb_i(stb), .sample_row_i(row), .trip_i(trip),
		.trigger_equation_i(eqn), .arc_flash_i(arc), .fault_valid_i(fv),
		.fault_code_i(4'h0), .oc_trip_i(oc), .cause_hi_i(hi), .freq_trip_i(fq),
		.freq_pickup_i({6{16'h1700}}), .cause_mid_i(mid), .uv_trip_i(uv),
		.potential_loss_flag_i(potential_loss_flag), .cause_lo_i(lo), .phase_inv_i(3'h1),
		.resid_pickup_i(1'b1), .target_reset_i(trst), .store_wr_o(wr),
		.store_addr_o(sa), .store_wdata_o(wdata), .commit_o(cmt), .commit_slot_o(cs),
		.erase_o(ers), .auto_msg_o(amsg), .phase_flag_o(pf), .ground_fault_flag_o(gnd),
		.target_latch_o(tl));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Signals sampled at the falling edge equal what the next rising edge sees.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic rdy;
		@(posedge clk_sys_i);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do begin @(negedge clk_sys_i); rdy = hro; @(posedge clk_sys_i); end while (rdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do begin @(negedge clk_sys_i); rdy = hro; r = hrdata; @(posedge clk_sys_i); end
		while (rdy !== 1'b1);
	endtask
	task automatic after_stb;
		do @(negedge clk_sys_i); while (stb !== 1'b1);
		@(posedge clk_sys_i);
	endtask
	task automatic wait_commit(input int n_exp);
		int n;
		int k;
		logic [3:0] g;
		n = 0;
		g = 4'h0;
		for (k = 0; k < 2000 && cmt !== 1'b1; k++)
		begin
			@(negedge clk_sys_i);
			g = g | {gnd, pf};
			if (cmt !== 1'b1) n = n + stb;
		end
		chk("commit", 32'h1, {31'h0, cmt});
		chk("auto_msg", 32'h5, {28'h0, amsg});
		if (n_exp > 0) chk("post_rows", n_exp, n);
		chk("flags_seen", 32'h9, {28'h0, g});
		chk("flags_held", 32'h0, {28'h0, gnd, pf});
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		#100000;
		n_mismatch++;
		conclude();
	end
	initial
	begin
		repeat (6) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		@(posedge clk_sys_i);
		xfer(1'b0, 8'h00, 32'h0); chk("ctrl_rst", 32'h400, r);
		xfer(1'b0, 8'h08, 32'h0); chk("nom_rst", 32'h1770, r);
		xfer(1'b0, 8'hfc, 32'h0); chk("unmapped", 32'h0, r);
		xfer(1'b1, 8'h00, 32'h50100);
		xfer(1'b1, 8'h00, 32'h50b00);
		xfer(1'b0, 8'h00, 32'h0); chk("ctrl_pre", 32'h50100, r);
		$display("registers done");
		for (i = 0; i < 11; i++)
		begin
			{arc, fv, oc, hi, fq, uv, potential_loss_flag, mid, lo} <= {tbl[i].arc, tbl[i].fv, tbl[i].oc,
				tbl[i].hi, tbl[i].fq, tbl[i].uv, tbl[i].potential_loss_flag, tbl[i].mid, tbl[i].lo};
			after_stb();
			trip <= 1'b1;
			wait_commit(56);
			trip <= 1'b0;
			chk("slot", i, {25'h0, cs});
			xfer(1'b0, 8'h10, 32'h0);
			chk("type", {tbl[i].oc, 4'h0, tbl[i].ev}, r & 32'h21f);
			xfer(1'b0, 8'h0c, 32'h0); chk("count", i + 1, r & 32'h7f);
		end
		$display("typing table done");
		{arc, fv, oc, hi, fq, uv, potential_loss_flag} <= '0;
		after_stb();
		trip <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		eqn <= 1'b1;
		// Two post rows have gone by before the wait starts.
		wait_commit(54);
		repeat (40) @(posedge clk_sys_i);
		xfer(1'b0, 8'h0c, 32'h0); chk("eqn_held", 32'hc, r & 32'h100007f);
		trip <= 1'b0;
		eqn <= 1'b0;
		after_stb();
		eqn <= 1'b1;
		wait_commit(56);
		xfer(1'b0, 8'h10, 32'h0); chk("eqn_type", FER_EV_EQN, r & 32'h1f);
		$display("equation done");
		xfer(1'b1, 8'h04, 32'h2);
		xfer(1'b0, 8'h0c, 32'h0); chk("cleared", 32'h0, r & 32'h7f);
		chk("erase1", 32'h1, n_erase);
		xfer(1'b1, 8'h04, 32'h1);
		wait_commit(56);
		xfer(1'b0, 8'h10, 32'h0); chk("cmd_type", FER_EV_CMD, r & 32'h1f);
		xfer(1'b1, 8'h00, 32'h50101);
		xfer(1'b0, 8'h0c, 32'h0); chk("len_erase", 32'h0, r & 32'h7f);
		chk("erase2", 32'h2, n_erase);
		xfer(1'b1, 8'h00, 32'h53c01);
		xfer(1'b0, 8'h00, 32'h0); chk("pre_long", 32'h50101, r);
		$display("clear and length done");
		xfer(1'b1, 8'h00, 32'hf50101);
		xfer(1'b1, 8'h04, 32'h1);
		trip <= 1'b1;
		repeat (2) @(negedge clk_sys_i);
		chk("target", 32'h9, {28'h0, tl});
		@(posedge clk_sys_i);
		trst <= 1'b1;
		repeat (2) @(negedge clk_sys_i);
		chk("target_rst", 32'h0, {28'h0, tl});
		$display("target latch done");
		conclude();
	end
endmodule // fault_event_recorder_test

// file: verif/fer_feed.sv
// Purpose: Sample source standing in for the protection side of the recorder.
// Assumes: One strobe every four clocks.
// Notes:   Row channels carry a running count.
`timescale 1ns/10ps
module fer_feed (
	input  wire logic          clk_sys_i,
	input  wire logic          reset_i,
	output logic               sample_stb_o,
	output logic [127:0]       sample_row_o
);
	logic [7:0] cnt_reg;
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			cnt_reg      <= 8'h00;
			sample_stb_o <= 1'b0;
		end
		else
		begin
			cnt_reg      <= cnt_reg + 8'h01;
			sample_stb_o <= (cnt_reg[1:0] == 2'h3);
		end
	end
	// Rows change every cycle, so a stale row cannot pass for a fresh one unless its age is a multiple of 256 clocks.
	always_ff @(posedge clk_sys_i)
		sample_row_o <= {8{8'h00, cnt_reg}};
endmodule // fer_feed
